//--- logic/pressure_sensor_host_port.sv
// SPI / I2C front end of the pressure sensor
`include "pressure_port_regs.svh"
`default_nettype none
module pressure_sensor_host_port #(
    parameter int DETECT_CYCLES = `DETECT_DELAY_CYCLES,
    parameter int SETTLE_CYCLES = `SETTLE_TIME_CYCLES
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // spi pins, sck doubles as i2c scl
    input wire logic ss_n_i,
    input wire logic sck_i,
    input wire logic mosi_i,
    output logic miso_o,
    // i2c data pin, open drain
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // level code of the divider on the clock pin
    input wire logic [3:0] addr_code_i,
    // sample engine
    input wire logic sample_tick_i,
    input wire pressure_port_pkg::word_t pressure_i,
    // status
    output logic new_sample_flag_o,
    output logic detect_done_o,
    output logic spi_sel_o,
    output logic i2c_sel_o,
    output logic settled_o,
    output logic [6:0] i2c_addr_o,
    // configuration towards the signal path
    output logic [2:0] range_o,
    output logic watchdog_en_o,
    output logic [2:0] bw_sel_o,
    output logic notch_en_o,
    output pressure_port_pkg::cfg_byte_t rate_o
);
    import pressure_port_pkg::*;

    logic [7:0] pins_s;
    logic ss_s, sck_s, mosi_s, sda_s;
    logic [3:0] code_s;

    pin_sync #(.W(8)) u_sync (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .pin_i({addr_code_i, sda_i, mosi_i, sck_i, ss_n_i}),
        .sync_o(pins_s)
    );
    assign {code_s, sda_s, mosi_s, sck_s, ss_s} = pins_s;

    // registered state and next values
    logic [`UP_CNT_W-1:0] up_cnt, next_up_cnt;
    logic detect_done, next_detect_done, spi_sel, next_spi_sel, i2c_sel, next_i2c_sel;
    logic settled, next_settled;
    logic [6:0] i2c_addr, next_i2c_addr;
    logic ss_q, sck_q, sda_q;
    cfg_byte_t mode_reg, next_mode_reg, mode_applied, next_mode_applied;
    cfg_byte_t rate_reg, next_rate_reg, rate_cnt, next_rate_cnt;
    logic flag, next_flag;
    word_t rx, next_rx, tx, next_tx;
    logic [4:0] bit_cnt, next_bit_cnt;
    logic miso, next_miso, sda_oe, next_sda_oe;
    i2c_state_t i_st, next_i_st;
    logic [3:0] i_cnt, next_i_cnt;
    logic [7:0] i_sh, next_i_sh;
    logic i_rw, next_i_rw;
    logic [1:0] i_wcnt, next_i_wcnt;
    cfg_byte_t buf_mode, next_buf_mode, buf_rate, next_buf_rate;
    logic got_mode, next_got_mode, got_rate, next_got_rate;

    // per cycle helpers
    logic ss_fall, sck_rise, sck_fall, i2c_start, i2c_stop;
    logic read_evt, cycle_end, tick_hit, new_mode_ok, new_rate_ok;
    cfg_byte_t new_mode_v, new_rate_v, reload, auto_div;
    word_t frame_word;

    assign ss_fall = ss_q & ~ss_s;
    assign sck_rise = sck_s & ~sck_q;
    assign sck_fall = ~sck_s & sck_q;
    assign i2c_start = sck_s & sck_q & sda_q & ~sda_s;
    assign i2c_stop = sck_s & sck_q & ~sda_q & sda_s;

    always_comb
    begin
        case (mode_applied[`MODE_BW_MSB:`MODE_BW_LSB])
            3'h0: auto_div = `AUTO_DIV_0;
            3'h1: auto_div = `AUTO_DIV_1;
            3'h2: auto_div = `AUTO_DIV_2;
            3'h3: auto_div = `AUTO_DIV_3;
            3'h4: auto_div = `AUTO_DIV_4;
            3'h5: auto_div = `AUTO_DIV_5;
            3'h6: auto_div = `AUTO_DIV_6;
            default: auto_div = `AUTO_DIV_7;
        endcase
        reload = (rate_reg == 8'h00) ? auto_div : rate_reg; // R15
        tick_hit = sample_tick_i && (rate_cnt == 8'h00);
    end

    always_comb
    begin
        next_up_cnt = up_cnt;
        next_detect_done = detect_done;
        next_spi_sel = spi_sel;
        next_i2c_sel = i2c_sel;
        next_settled = settled;
        next_i2c_addr = i2c_addr;
        next_mode_reg = mode_reg;
        next_mode_applied = mode_applied;
        next_rate_reg = rate_reg;
        next_rate_cnt = rate_cnt;
        next_flag = flag;
        next_rx = rx;
        next_tx = tx;
        next_bit_cnt = bit_cnt;
        next_miso = miso;
        next_sda_oe = sda_oe;
        next_i_st = i_st;
        next_i_cnt = i_cnt;
        next_i_sh = i_sh;
        next_i_rw = i_rw;
        next_i_wcnt = i_wcnt;
        next_buf_mode = buf_mode;
        next_buf_rate = buf_rate;
        next_got_mode = got_mode;
        next_got_rate = got_rate;
        read_evt = 1'b0;
        cycle_end = 1'b0;
        new_mode_ok = 1'b0;
        new_rate_ok = 1'b0;
        new_mode_v = mode_reg;
        new_rate_v = rate_reg;
        frame_word = {rx[14:0], mosi_s};

        // power-up timing and one-shot interface detection
        if (up_cnt != SETTLE_CYCLES[`UP_CNT_W-1:0])
            next_up_cnt = up_cnt + 1'b1;
        if (up_cnt == SETTLE_CYCLES[`UP_CNT_W-1:0])
            next_settled = 1'b1; // R03
        if (!detect_done && up_cnt == DETECT_CYCLES[`UP_CNT_W-1:0])
        begin
            next_detect_done = 1'b1; // R01
            next_spi_sel = ss_s; // R01
            next_i2c_sel = ~ss_s; // R01
            next_i2c_addr = `I2C_ADDR_BASE
                + {3'h0, (code_s > `I2C_ADDR_STEPS) ? `I2C_ADDR_STEPS : code_s}; // R11 R12
        end

        // spi: sample mosi on rising sck, shift miso on falling sck
        if (spi_sel)
        begin
            if (ss_fall)
            begin
                read_evt = 1'b1; // R09
                next_tx = pressure_i; // R05
                next_miso = pressure_i[15]; // R04
                next_bit_cnt = 5'h00;
            end
            else if (!ss_s && sck_rise && bit_cnt != `SPI_FRAME_BITS)
            begin
                next_rx = frame_word; // R04
                next_bit_cnt = bit_cnt + 1'b1;
                if (bit_cnt == `SPI_FRAME_BITS - 5'h01)
                begin
                    cycle_end = 1'b1;
                    new_mode_ok = 1'b1; // R05 R06
                    new_rate_ok = 1'b1;
                    new_mode_v = frame_word[15:8];
                    new_rate_v = frame_word[7:0];
                end
            end
            else if (!ss_s && sck_fall)
            begin
                next_tx = {tx[14:0], 1'b0}; // R04
                next_miso = (bit_cnt == `SPI_FRAME_BITS) ? 1'b0 : tx[14];
            end
        end

        // i2c slave: master owns every clock edge
        if (i2c_sel)
        begin
            if (i2c_start)
            begin
                next_i_st = I_ADDR; // R13
                next_i_cnt = 4'h0;
                next_sda_oe = 1'b0;
            end
            else if (i2c_stop)
            begin
                next_i_st = I_IDLE;
                next_sda_oe = 1'b0;
                cycle_end = 1'b1; // R14
                new_mode_ok = got_mode;
                new_rate_ok = got_rate;
                new_mode_v = buf_mode;
                new_rate_v = buf_rate;
                next_got_mode = 1'b0;
                next_got_rate = 1'b0;
            end
            else if (sck_rise)
            begin
                if (i_st == I_ADDR || i_st == I_WR)
                begin
                    next_i_sh = {i_sh[6:0], sda_s};
                    next_i_cnt = i_cnt + 1'b1;
                end
                else if (i_st == I_RD)
                    next_i_cnt = i_cnt + 1'b1;
                else if (i_st == I_RD_ACK && sda_s)
                    next_i_st = I_IDLE; // master nack ends the read
            end
            else if (sck_fall)
            begin
                case (i_st)
                    I_ADDR:
                        if (i_cnt == `I2C_BYTE_BITS)
                        begin
                            if (i_sh[7:1] == i2c_addr)
                            begin
                                next_i_st = I_ADDR_ACK;
                                next_i_rw = i_sh[0];
                                next_sda_oe = 1'b1;
                            end
                            else
                                next_i_st = I_IDLE;
                        end
                    I_ADDR_ACK:
                    begin
                        next_i_cnt = 4'h0;
                        if (i_rw)
                        begin
                            read_evt = 1'b1; // R09 R14
                            next_i_st = I_RD;
                            next_tx = pressure_i;
                            next_sda_oe = ~pressure_i[15];
                        end
                        else
                        begin
                            next_i_st = I_WR; // R14
                            next_i_wcnt = 2'h0;
                            next_sda_oe = 1'b0;
                        end
                    end
                    I_WR:
                        if (i_cnt == `I2C_BYTE_BITS)
                        begin
                            next_i_st = I_WR_ACK;
                            next_sda_oe = 1'b1;
                            if (i_wcnt == 2'h0)
                            begin
                                next_buf_mode = i_sh;
                                next_got_mode = 1'b1;
                            end
                            else if (i_wcnt == 2'h1)
                            begin
                                next_buf_rate = i_sh;
                                next_got_rate = 1'b1;
                            end
                            if (i_wcnt != 2'h3)
                                next_i_wcnt = i_wcnt + 1'b1;
                        end
                    I_WR_ACK:
                    begin
                        next_i_st = I_WR;
                        next_i_cnt = 4'h0;
                        next_sda_oe = 1'b0;
                    end
                    I_RD:
                        if (i_cnt == `I2C_BYTE_BITS)
                        begin
                            next_i_st = I_RD_ACK;
                            next_sda_oe = 1'b0;
                        end
                        else
                        begin
                            next_tx = {tx[14:0], 1'b1};
                            next_sda_oe = ~tx[14];
                        end
                    I_RD_ACK:
                    begin
                        next_i_st = I_RD;
                        next_i_cnt = 4'h0;
                        next_tx = {tx[14:0], 1'b1};
                        next_sda_oe = ~tx[14];
                    end
                    default:
                        next_sda_oe = 1'b0;
                endcase
            end
        end

        // mode takes effect one cycle late, rate at once
        if (cycle_end)
            next_mode_applied = mode_reg; // R17
        if (new_mode_ok)
            next_mode_reg = new_mode_v; // R05
        if (new_rate_ok)
            next_rate_reg = new_rate_v; // R05

        // divided notification pacing, a set beats a clearing read
        if (sample_tick_i)
            next_rate_cnt = tick_hit ? reload - 8'h01 : rate_cnt - 8'h01; // R15
        if (tick_hit)
            next_flag = 1'b1; // R08
        else if (read_evt)
            next_flag = 1'b0; // R09
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            up_cnt <= '0;
            detect_done <= 1'b0;
            spi_sel <= 1'b0;
            i2c_sel <= 1'b0;
            settled <= 1'b0;
            i2c_addr <= `I2C_ADDR_BASE;
            ss_q <= 1'b0;
            sck_q <= 1'b0;
            sda_q <= 1'b0;
            mode_reg <= `MODE_RESET;
            mode_applied <= `MODE_RESET;
            rate_reg <= `RATE_RESET;
            rate_cnt <= 8'h00;
            flag <= 1'b0;
            rx <= 16'h0000;
            tx <= 16'h0000;
            bit_cnt <= 5'h00;
            miso <= 1'b0;
            sda_oe <= 1'b0;
            sda_o <= 1'b0;
            i_st <= I_IDLE;
            i_cnt <= 4'h0;
            i_sh <= 8'h00;
            i_rw <= 1'b0;
            i_wcnt <= 2'h0;
            buf_mode <= 8'h00;
            buf_rate <= 8'h00;
            got_mode <= 1'b0;
            got_rate <= 1'b0;
        end
        else
        begin
            up_cnt <= next_up_cnt;
            detect_done <= next_detect_done;
            spi_sel <= next_spi_sel;
            i2c_sel <= next_i2c_sel;
            settled <= next_settled;
            i2c_addr <= next_i2c_addr;
            ss_q <= ss_s;
            sck_q <= sck_s;
            sda_q <= sda_s;
            mode_reg <= next_mode_reg;
            mode_applied <= next_mode_applied;
            rate_reg <= next_rate_reg;
            rate_cnt <= next_rate_cnt;
            flag <= next_flag;
            rx <= next_rx;
            tx <= next_tx;
            bit_cnt <= next_bit_cnt;
            miso <= next_miso;
            sda_oe <= next_sda_oe;
            sda_o <= 1'b0;
            i_st <= next_i_st;
            i_cnt <= next_i_cnt;
            i_sh <= next_i_sh;
            i_rw <= next_i_rw;
            i_wcnt <= next_i_wcnt;
            buf_mode <= next_buf_mode;
            buf_rate <= next_buf_rate;
            got_mode <= next_got_mode;
            got_rate <= next_got_rate;
        end
    end

    assign miso_o = miso;
    assign sda_oe_o = sda_oe;
    assign new_sample_flag_o = flag;
    assign detect_done_o = detect_done;
    assign spi_sel_o = spi_sel;
    assign i2c_sel_o = i2c_sel;
    assign settled_o = settled;
    assign i2c_addr_o = i2c_addr;
    assign range_o = mode_applied[`MODE_RANGE_MSB:`MODE_RANGE_LSB]; // R10 R16
    assign watchdog_en_o = mode_applied[`MODE_WDOG_BIT]; // R16
    assign bw_sel_o = mode_applied[`MODE_BW_MSB:`MODE_BW_LSB]; // R10 R16
    assign notch_en_o = mode_applied[`MODE_NOTCH_BIT]; // R10 R16
    assign rate_o = rate_reg;

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);

    a_detect_moment: assert property ($rose(detect_done) |-> // R01
        $past(up_cnt) == DETECT_CYCLES[`UP_CNT_W-1:0]) else $error("detect at wrong time");
    a_detect_sticky: assert property (detect_done |=> detect_done && $stable(spi_sel)) // R01
        else $error("interface choice changed");
    a_sel_exclusive: assert property (detect_done |-> spi_sel != i2c_sel) // R01
        else $error("interface select not exclusive");
    a_settle_time: assert property (settled |-> up_cnt == SETTLE_CYCLES[`UP_CNT_W-1:0]) // R03
        else $error("settled flag early");
    a_spi_frame_len: assert property (bit_cnt <= `SPI_FRAME_BITS) // R04
        else $error("spi frame longer than 16 bits");
    a_flag_set: assert property (tick_hit |=> // R08 R15
        flag && rate_cnt == $past(reload) - 8'h01) else $error("flag or divider reload wrong");
    a_flag_clear: assert property (read_evt && !tick_hit |=> !flag) // R09
        else $error("read did not clear flag");
    a_addr_ground: assert property ($rose(detect_done) && $past(code_s) == 4'h0 |-> // R11
        i2c_addr == `I2C_ADDR_BASE) else $error("grounded address not base");
    a_addr_range: assert property (detect_done |-> i2c_addr >= 7'h28 && i2c_addr <= 7'h31) // R12
        else $error("i2c address out of range");
    a_i2c_quiet: assert property (!i2c_sel |-> !sda_oe) // R13
        else $error("sda driven outside i2c mode");
    a_mode_latency: assert property (cycle_end |=> mode_applied == $past(mode_reg)) // R17
        else $error("mode applied with wrong latency");
endmodule : pressure_sensor_host_port
`default_nettype wire

//--- logic/pressure_port_regs.svh
// constants for the pressure sensor host port
// Operation
// R01 - after the power-up delay the select pin is sampled once, high picks SPI, low picks I2C.
// R02 - the host keeps the bus quiet while the interface is being detected.
// R03 - samples taken before the filter settle time has passed are not yet reliable.
// R04 - every SPI transfer is 16 bits, shifted most significant bit first both ways.
// R05 - each SPI cycle loads a mode byte then a rate byte while the pressure word goes out.
// R06 - the host sends real mode and rate bytes every cycle and never echoes pressure back.
// R07 - the SPI master keeps the minimum select, byte gap, clock and deselect timings.
// R08 - the new sample flag is raised at a pace set by the rate register.
// R09 - any read over the active interface clears the new sample flag.
// R10 - the mode register picks pressure range, filter corner and the mains notch filter.
// R11 - a grounded clock pin at detection gives I2C address 0x28.
// R12 - the clock pin divider level maps to one of ten addresses from 0x28 to 0x31.
// R13 - on I2C the sensor is only a slave and the master makes every clock pulse.
// R14 - on I2C configuration writes and pressure reads are separate transactions.
// R15 - the rate value reloads a divider of the update tick, zero picks an automatic rate.
// R16 - mode bits 0-2 range, bit 3 watchdog, bits 4-6 filter corner, bit 7 notch filter.
// R17 - a new mode value first shows in the data of the second cycle after the write.
`ifndef PRESSURE_PORT_REGS_SVH
`define PRESSURE_PORT_REGS_SVH

`define CLK_HZ 40000000
`define DETECT_DELAY_MS 40
`define DETECT_DELAY_CYCLES (`DETECT_DELAY_MS * (`CLK_HZ / 1000))
`define SETTLE_TIME_MS 80
`define SETTLE_TIME_CYCLES (`SETTLE_TIME_MS * (`CLK_HZ / 1000))
`define UP_CNT_W 22

`define MODE_RESET 8'hF6
`define RATE_RESET 8'h00
`define MODE_RANGE_LSB 0
`define MODE_RANGE_MSB 2
`define MODE_WDOG_BIT 3
`define MODE_BW_LSB 4
`define MODE_BW_MSB 6
`define MODE_NOTCH_BIT 7

`define I2C_ADDR_BASE 7'h28
`define I2C_ADDR_STEPS 4'h9

`define SPI_FRAME_BITS 5'h10
`define I2C_BYTE_BITS 4'h8

`define AUTO_DIV_0 8'h94
`define AUTO_DIV_1 8'h4A
`define AUTO_DIV_2 8'h1E
`define AUTO_DIV_3 8'h0F
`define AUTO_DIV_4 8'h07
`define AUTO_DIV_5 8'h03
`define AUTO_DIV_6 8'h02
`define AUTO_DIV_7 8'h01

`endif

//--- logic/pressure_port_pkg.sv
// types for the pressure sensor host port
`default_nettype none
package pressure_port_pkg;
    typedef enum logic [2:0] {
        I_IDLE,
        I_ADDR,
        I_ADDR_ACK,
        I_WR,
        I_WR_ACK,
        I_RD,
        I_RD_ACK
    } i2c_state_t;
    typedef logic [7:0] cfg_byte_t;
    typedef logic [15:0] word_t;
endpackage : pressure_port_pkg
`default_nettype wire

//--- logic/pin_sync.sv
// two flop synchroniser for a group of pin inputs
`default_nettype none
module pin_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // pins and synchronised copies
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] sync_o
);
    genvar g;
    generate
        for (g = 0; g < W; g++)
        begin : g_bit
            logic meta;
            logic stable;
            always_ff @(posedge ref_clk_i or negedge resetn_i)
            begin
                if (!resetn_i)
                begin
                    meta <= 1'b0;
                    stable <= 1'b0;
                end
                else
                begin
                    meta <= pin_i[g];
                    stable <= meta;
                end
            end
            assign sync_o[g] = stable;
        end
    endgenerate
endmodule : pin_sync
`default_nettype wire

//--- verification/host_master.sv
// host model: spi and i2c master driving the sensor pins
`default_nettype none
module host_master (
    // clock
    input wire logic clk_i,
    // pins
    output var logic ss_n_o,
    output var logic sck_o,
    output var logic mosi_o,
    input wire logic miso_i,
    output var logic sda_rel_o,
    input wire logic sda_i
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int select_to_first_edge_time = 4000;
    localparam int inter_byte_gap = 4000;
    localparam int T_HALF = 120;
    localparam int last_clock_to_deselect_time = 800;
    localparam int Q = 30;
    initial
    begin
        ss_n_o = 1'b1;
        sck_o = 1'b0;
        mosi_o = 1'b0;
        sda_rel_o = 1'b1;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask : wt
    task automatic strap(input logic spi);
        ss_n_o <= spi;
        sck_o <= !spi;
        sda_rel_o <= 1'b1;
    endtask : strap
    // mode byte then rate byte, every gap at its minimum
    task automatic spi_frame(input logic [15:0] tx, output logic [15:0] rx);
        ss_n_o <= 1'b0;
        wt(select_to_first_edge_time);
        for (int i = 15; i >= 0; i--)
        begin
            mosi_o <= tx[i];
            wt(T_HALF);
            sck_o <= 1'b1;
            rx[i] = miso_i;
            wt(T_HALF);
            sck_o <= 1'b0;
            if (i == 8)
                wt(inter_byte_gap);
        end
        wt(last_clock_to_deselect_time);
        ss_n_o <= 1'b1;
        mosi_o <= ~mosi_o;
        wt(last_clock_to_deselect_time);
    endtask : spi_frame
    task automatic i2c_bit(input logic b, output logic s);
        sda_rel_o <= b;
        wt(Q);
        sck_o <= 1'b1;
        wt(Q);
        s = sda_i;
        wt(Q);
        sck_o <= 1'b0;
        wt(Q);
    endtask : i2c_bit
    task automatic i2c_byte(input logic [7:0] tx, input logic a, output logic [7:0] rx,
        output logic s);
        for (int i = 7; i >= 0; i--)
            i2c_bit(tx[i], rx[i]);
        i2c_bit(a, s);
    endtask : i2c_byte
    task automatic i2c_start();
        sck_o <= 1'b1;
        wt(Q);
        sda_rel_o <= 1'b0;
        wt(Q);
        sck_o <= 1'b0;
        wt(Q);
    endtask : i2c_start
    task automatic i2c_stop();
        sda_rel_o <= 1'b0;
        wt(Q);
        sck_o <= 1'b1;
        wt(Q);
        sda_rel_o <= 1'b1;
        wt(Q);
    endtask : i2c_stop
endmodule : host_master
`default_nettype wire

//--- verification/tb.sv
// self-checking bench for the pressure sensor host port
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pressure_port_pkg::*;
    typedef struct {cfg_byte_t m; cfg_byte_t r; word_t p;} row_t;
    row_t rows[3] = '{'{8'h81, 8'h05, 16'hA55A}, '{8'h5A, 8'h00, 16'h0001},
        '{8'h70, 8'h03, 16'h8000}};
    logic [3:0] codes[4] = '{4'h0, 4'h4, 4'h9, 4'hC};
    logic clk, resetn, tick, s;
    logic [3:0] code;
    word_t pres, rx;
    cfg_byte_t prev, hi, lo;
    int miscompares = 0;
    int tests_run = 0;
    wire logic ss_n, sck, mosi, miso, sda_rel, sda_oe, flag, det, spi_sel, i2c_sel;
    wire logic settled, wdog, notch, sda, sda_val;
    wire logic [6:0] addr;
    wire logic [2:0] range, bw;
    wire cfg_byte_t rate;
    // open drain data line, pulled up
    assign sda = sda_rel & (~sda_oe | sda_val);
    pressure_sensor_host_port #(
        .DETECT_CYCLES(50),
        .SETTLE_CYCLES(100)
    ) pressure_sensor_host_port_inst (
        .ref_clk_i(clk), .resetn_i(resetn), .ss_n_i(ss_n), .sck_i(sck), .mosi_i(mosi),
        .miso_o(miso), .sda_i(sda), .sda_o(sda_val), .sda_oe_o(sda_oe), .addr_code_i(code),
        .sample_tick_i(tick), .pressure_i(pres), .new_sample_flag_o(flag),
        .detect_done_o(det), .spi_sel_o(spi_sel), .i2c_sel_o(i2c_sel), .settled_o(settled),
        .i2c_addr_o(addr), .range_o(range), .watchdog_en_o(wdog), .bw_sel_o(bw),
        .notch_en_o(notch), .rate_o(rate)
    );
    host_master host_master_inst (.clk_i(clk), .ss_n_o(ss_n), .sck_o(sck), .mosi_o(mosi),
        .miso_i(miso), .sda_rel_o(sda_rel), .sda_i(sda));
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : tally_and_finish
    task automatic do_reset(input logic spi, input logic [3:0] c);
        @(posedge clk);
        resetn <= 1'b0;
        code <= c;
        host_master_inst.strap(spi);
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        for (int k = 0; k < 200 && det !== 1'b1; k++)
            @(posedge clk);
        repeat (4) @(posedge clk);
    endtask : do_reset
    task automatic frame(input cfg_byte_t m, input cfg_byte_t r, input word_t p);
        @(posedge clk);
        pres <= p;
        host_master_inst.spi_frame({m, r}, rx);
        repeat (3) @(posedge clk);
    endtask : frame
    task automatic pulse(input int n);
        repeat (n)
        begin
            @(posedge clk);
            tick <= 1'b1;
            @(posedge clk);
            tick <= 1'b0;
        end
        repeat (3) @(posedge clk);
    endtask : pulse
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial
    begin
        repeat (100000) @(posedge clk);
        miscompares++;
        tally_and_finish();
    end
    initial
    begin
        resetn = 1'b0;
        tick = 1'b0;
        code = 4'h0;
        pres = 16'h0000;
        do_reset(1'b1, 4'h0);
        check("select", 16'({det, spi_sel, i2c_sel}), 16'h0006);
        check("settled early", 16'(settled), 16'h0000);
        prev = 8'hF6;
        foreach (rows[i])
        begin
            frame(rows[i].m, rows[i].r, rows[i].p);
            check("spi word", rx, rows[i].p);
            check("rate", 16'(rate), 16'(rows[i].r));
            check("mode", 16'({notch, bw, wdog, range}), 16'(prev));
            prev = rows[i].m;
        end
        check("settled", 16'(settled), 16'h0001);
        pulse(1);
        check("flag set", 16'(flag), 16'h0001);
        frame(8'h70, 8'h00, 16'h1234);
        check("flag cleared", 16'(flag), 16'h0000);
        pulse(2);
        check("flag divided", 16'(flag), 16'h0000);
        pulse(1);
        check("flag reload", 16'(flag), 16'h0001);
        frame(8'h70, 8'h00, 16'h1234);
        pulse(1);
        check("flag auto", 16'(flag), 16'h0001);
        foreach (codes[i])
        begin
            do_reset(1'b0, codes[i]);
            check("i2c select", 16'({det, spi_sel, i2c_sel}), 16'h0005);
            check("address", 16'(addr),
                16'h0028 + (codes[i] > 4'h9 ? 16'h0009 : 16'(codes[i])));
        end
        host_master_inst.i2c_start();
        host_master_inst.i2c_byte({7'h30, 1'b0}, 1'b1, hi, s);
        check("foreign address", 16'(s), 16'h0001);
        host_master_inst.i2c_stop();
        host_master_inst.i2c_start();
        host_master_inst.i2c_byte({7'h31, 1'b0}, 1'b1, hi, s);
        check("address ack", 16'(s), 16'h0000);
        host_master_inst.i2c_byte(8'h12, 1'b1, hi, s);
        host_master_inst.i2c_byte(8'h07, 1'b1, hi, s);
        host_master_inst.i2c_stop();
        repeat (4) @(posedge clk);
        check("i2c rate", 16'(rate), 16'h0007);
        check("i2c mode", 16'({notch, bw, wdog, range}), 16'h00F6);
        pulse(1);
        check("i2c flag", 16'(flag), 16'h0001);
        @(posedge clk);
        pres <= 16'hC3A5;
        host_master_inst.i2c_start();
        host_master_inst.i2c_byte({7'h31, 1'b1}, 1'b1, hi, s);
        host_master_inst.i2c_byte(8'hFF, 1'b0, hi, s);
        host_master_inst.i2c_byte(8'hFF, 1'b1, lo, s);
        host_master_inst.i2c_stop();
        check("i2c read", {hi, lo}, 16'hC3A5);
        check("i2c flag clear", 16'(flag), 16'h0000);
        check("i2c mode late", 16'({notch, bw, wdog, range}), 16'h0012);
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
